/* File: sync_blank_pkg.sv */
// Package of constants and types for the video sync and blank pipeline
`default_nettype none
package sync_blank_pkg;
    // Register offsets
    localparam logic [3:0] OFS_SYNC_CTRL = 4'h0;
    localparam logic [3:0] OFS_HPOS = 4'h1;
    localparam logic [3:0] OFS_STATUS = 4'h2;
    // Sync control field positions
    localparam int POS_COMPOSITE = 0;
    localparam int POS_INTERLACE = 1;
    localparam int POS_HINV = 2;
    localparam int POS_VINV = 3;
    localparam int POS_HMODE = 4;
    localparam int POS_VMODE = 6;
    localparam int POS_CSYNC_EN = 8;
    localparam int POS_CURSOR_EN = 9;
    // Output modes
    localparam logic [1:0] OMODE_PASS = 2'h0;
    localparam logic [1:0] OMODE_HIGH = 2'h1;
    localparam logic [1:0] OMODE_LOW = 2'h2;
    localparam logic [1:0] OMODE_HIZ = 2'h3;
    // Reset values
    localparam logic [15:0] RST_SYNC_CTRL = 16'h0000;
    localparam logic [3:0] RST_HPOS = 4'h0;
    // Nominal and maximum pixel pipeline latency in pixel clocks
    localparam int PIPE_NOMINAL = 8;
    localparam int PIPE_MAX = 16;

    typedef enum logic [2:0] {
        SRC_BLANK = 3'b001,
        SRC_BORDER = 3'b010,
        SRC_PIXEL = 3'b100
    } video_src_e;

    typedef struct packed {
        logic blank_n;
        logic shared;
        logic line_sync;
        logic frame_sync;
    } ctl_in_s;

    typedef struct packed {
        logic line_sync;
        logic line_sync_oe_n;
        logic frame_sync;
        logic frame_sync_oe_n;
    } sync_out_s;
endpackage : sync_blank_pkg
`default_nettype wire

/* File: video_sync_blank_pipeline.sv */
// Video control input latching, sync pipeline and output source selection
`default_nettype none

module video_sync_blank_pipeline
    import sync_blank_pkg::*;
#(
    parameter int PIPE_DELAY = PIPE_NOMINAL
)(
    input wire logic mclk,                 // Pixel clock, 250 MHz
    input wire logic reset_n,              // Async reset, active low
    input wire logic load_clock,           // Load clock from controller, sampled
    input wire ctl_in_s ctl_in,            // Video control pins
    input wire logic [3:0] reg_addr,       // Register address
    input wire logic [15:0] reg_wdata,     // Register write data
    input wire logic reg_wr,               // Write strobe
    input wire logic reg_rd,               // Read strobe
    output logic [15:0] reg_rdata,         // Read data, cycle after strobe
    output sync_out_s sync_out,            // Sync pins, enables active low
    output logic [2:0] video_src,          // One-hot video source select
    output logic csync_to_green,           // Sync level added to green DAC
    output logic cursor_row_odd            // Cursor row for current field
);

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [15:0] ctrl_ff;
    logic [3:0] hpos_ff;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_ff <= RST_SYNC_CTRL;
            hpos_ff <= RST_HPOS;
        end
        else if (reg_wr)
        begin
            if (reg_addr == OFS_SYNC_CTRL)
                ctrl_ff <= reg_wdata;
            if (reg_addr == OFS_HPOS)
                hpos_ff <= reg_wdata[3:0];
        end
    end

    logic composite, interlace, hinv, vinv, csync_en, cursor_en;
    logic [1:0] hmode, vmode;
    assign composite = ctrl_ff[POS_COMPOSITE];
    assign interlace = ctrl_ff[POS_INTERLACE];
    assign hinv = ctrl_ff[POS_HINV];
    assign vinv = ctrl_ff[POS_VINV];
    assign hmode = ctrl_ff[POS_HMODE +: 2];
    assign vmode = ctrl_ff[POS_VMODE +: 2];
    assign csync_en = ctrl_ff[POS_CSYNC_EN];
    assign cursor_en = ctrl_ff[POS_CURSOR_EN];

    // ----------------------------------------------------------------
    // Pin synchronisers and load clock edge
    // ----------------------------------------------------------------
    // Pins come from the controller's domain, so two flops before use
    logic [4:0] sync1_ff, sync2_ff;
    logic load_clock_prev_ff;
    ctl_in_s pins;
    logic load_clock_s;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_ff <= 5'h00;
            sync2_ff <= 5'h00;
            load_clock_prev_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= {load_clock, ctl_in};
            sync2_ff <= sync1_ff;
            load_clock_prev_ff <= sync2_ff[4];
        end
    end

    assign load_clock_s = sync2_ff[4];
    assign pins = sync2_ff[3:0];

    logic load_clock_rise;
    assign load_clock_rise = load_clock_s && !load_clock_prev_ff;

    // ----------------------------------------------------------------
    // Control input latches on load clock rising edge
    // ----------------------------------------------------------------
    ctl_in_s lat_ff;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            lat_ff <= '0;
        else if (load_clock_rise)
            lat_ff <= pins;
    end

    // ----------------------------------------------------------------
    // Video source selection
    // ----------------------------------------------------------------
    // Border indicator only meaningful outside interlace use of the pin
    logic border_n;
    assign border_n = interlace ? 1'b1 : lat_ff.shared;

    video_src_e nxt_src;
    always_comb
    begin
        if (!lat_ff.blank_n)
            nxt_src = SRC_BLANK;
        else if (!border_n)
            nxt_src = SRC_BORDER;
        else
            nxt_src = SRC_PIXEL;
    end

    logic [2:0] video_src_ff;
    logic cursor_row_ff;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            video_src_ff <= SRC_BLANK;
        else
            video_src_ff <= nxt_src;
    end

    // Field parity held when cursor off, so row choice never glitches
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            cursor_row_ff <= 1'b0;
        else if (interlace && cursor_en)
            cursor_row_ff <= lat_ff.shared;
    end

    // ----------------------------------------------------------------
    // Line sync delay pipeline
    // ----------------------------------------------------------------
    logic [PIPE_MAX-1:0] hpipe_ff;
    logic hsync_pol;
    assign hsync_pol = lat_ff.line_sync ^ hinv;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            hpipe_ff <= '0;
        else
            hpipe_ff <= {hpipe_ff[PIPE_MAX-2:0], hsync_pol};
    end

    // Signed shift, clamped so the tap stays inside the pipe
    logic [4:0] tap;
    always_comb
    begin
        int t;
        t = PIPE_DELAY + $signed(hpos_ff);
        if (t < 1)
            t = 1;
        if (t > PIPE_MAX)
            t = PIPE_MAX;
        tap = 5'(t - 1);
    end

    logic hsync_dly;
    assign hsync_dly = hpipe_ff[tap[3:0]];

    // ----------------------------------------------------------------
    // Sync outputs
    // ----------------------------------------------------------------
    function automatic logic [1:0] drive_sync(input logic [1:0] mode, input logic val);
        logic [1:0] r;
        r = {val, 1'b0};
        unique case (mode)
            OMODE_PASS: r = {val, 1'b0};
            OMODE_HIGH: r = {1'b1, 1'b0};
            OMODE_LOW: r = {1'b0, 1'b0};
            OMODE_HIZ: r = {1'b0, 1'b1};
        endcase
        return r;
    endfunction

    sync_out_s sync_ff;
    logic csync_ff;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            sync_ff <= '{line_sync: 1'b0, line_sync_oe_n: 1'b0,
                         frame_sync: 1'b0, frame_sync_oe_n: 1'b0};
        else
        begin
            {sync_ff.line_sync, sync_ff.line_sync_oe_n} <=
                drive_sync(hmode, composite ? 1'b0 : hsync_dly);
            {sync_ff.frame_sync, sync_ff.frame_sync_oe_n} <=
                drive_sync(vmode, lat_ff.frame_sync ^ vinv);
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            csync_ff <= 1'b0;
        else
            csync_ff <= composite && csync_en && hsync_dly;
    end

    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                OFS_SYNC_CTRL: reg_rdata <= ctrl_ff;
                OFS_HPOS: reg_rdata <= {12'h000, hpos_ff};
                OFS_STATUS: reg_rdata <= {11'h000, cursor_row_ff, lat_ff};
                default: reg_rdata <= 16'h0000;
            endcase
        end
        else
            reg_rdata <= 16'h0000;
    end

    assign sync_out = sync_ff;
    assign video_src = video_src_ff;
    assign csync_to_green = csync_ff;
    assign cursor_row_odd = cursor_row_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_blank_selects: assert property (@(posedge mclk) disable iff (!reset_n)
        !lat_ff.blank_n |=> video_src == SRC_BLANK)
        else $error("blank did not select blank source");
    a_border_select: assert property (@(posedge mclk) disable iff (!reset_n)
        lat_ff.blank_n && !interlace && !lat_ff.shared |=> video_src == SRC_BORDER)
        else $error("border not selected");
    a_interlace_nobord: assert property (@(posedge mclk) disable iff (!reset_n)
        lat_ff.blank_n && interlace |=> video_src == SRC_PIXEL)
        else $error("border shown in interlace mode");
    a_field_row: assert property (@(posedge mclk) disable iff (!reset_n)
        interlace && cursor_en |=> cursor_row_odd == $past(lat_ff.shared))
        else $error("cursor row not following field");
    a_latch_edge: assert property (@(posedge mclk) disable iff (!reset_n)
        !load_clock_rise |=> $stable(lat_ff))
        else $error("inputs latched off load edge");
    a_hsync_nominal: assert property (@(posedge mclk) disable iff (!reset_n)
        hmode == OMODE_PASS && !composite && hpos_ff == 4'h0 && $stable(ctrl_ff)
        |=> sync_out.line_sync == $past(hpipe_ff[PIPE_DELAY-1]))
        else $error("line sync delay wrong");
    a_hsync_force: assert property (@(posedge mclk) disable iff (!reset_n)
        hmode == OMODE_HIZ |=> sync_out.line_sync_oe_n)
        else $error("line sync not released");
    a_hsync_high: assert property (@(posedge mclk) disable iff (!reset_n)
        hmode == OMODE_HIGH |=> sync_out.line_sync && !sync_out.line_sync_oe_n)
        else $error("line sync not forced high");
    a_vsync_copy: assert property (@(posedge mclk) disable iff (!reset_n)
        vmode == OMODE_PASS |=> sync_out.frame_sync == $past(lat_ff.frame_sync ^ vinv))
        else $error("frame sync not copied");
    a_csync_green: assert property (@(posedge mclk) disable iff (!reset_n)
        !(composite && csync_en) |=> !csync_to_green)
        else $error("composite sync leaked to green");
    a_hpos_shift: assert property (@(posedge mclk) disable iff (!reset_n)
        hpos_ff == 4'h1 |-> tap == 5'(PIPE_DELAY))
        else $error("position shift wrong");
    a_reset_pass: assert property (@(posedge mclk)
        !reset_n |=> ctrl_ff == RST_SYNC_CTRL && hpos_ff == RST_HPOS)
        else $error("reset config wrong");

    a_pixel_select: assert property (@(posedge mclk) disable iff (!reset_n)
        lat_ff.blank_n && border_n |=> video_src == SRC_PIXEL)
        else $error("pixel source not selected");
    a_src_onehot: assert property (@(posedge mclk) disable iff (!reset_n)
        $onehot(video_src))
        else $error("video source not one-hot");
    a_load_latch: assert property (@(posedge mclk) disable iff (!reset_n)
        load_clock_rise |=> lat_ff == $past(pins))
        else $error("inputs not latched on load edge");
    a_hsync_low: assert property (@(posedge mclk) disable iff (!reset_n)
        hmode == OMODE_LOW |=> !sync_out.line_sync && !sync_out.line_sync_oe_n)
        else $error("line sync not forced low");
    a_hsync_drive: assert property (@(posedge mclk) disable iff (!reset_n)
        hmode != OMODE_HIZ |=> !sync_out.line_sync_oe_n)
        else $error("line sync released while driven");
    a_vsync_high: assert property (@(posedge mclk) disable iff (!reset_n)
        vmode == OMODE_HIGH |=> sync_out.frame_sync && !sync_out.frame_sync_oe_n)
        else $error("frame sync not forced high");
    a_vsync_low: assert property (@(posedge mclk) disable iff (!reset_n)
        vmode == OMODE_LOW |=> !sync_out.frame_sync && !sync_out.frame_sync_oe_n)
        else $error("frame sync not forced low");
    a_vsync_hiz: assert property (@(posedge mclk) disable iff (!reset_n)
        vmode == OMODE_HIZ |=> sync_out.frame_sync_oe_n)
        else $error("frame sync not released");
    a_vsync_drive: assert property (@(posedge mclk) disable iff (!reset_n)
        vmode != OMODE_HIZ |=> !sync_out.frame_sync_oe_n)
        else $error("frame sync released while driven");
    a_vsync_invert: assert property (@(posedge mclk) disable iff (!reset_n)
        vmode == OMODE_PASS && vinv |=> sync_out.frame_sync == !$past(lat_ff.frame_sync))
        else $error("frame sync not inverted");
    a_csync_path: assert property (@(posedge mclk) disable iff (!reset_n)
        composite && csync_en |=> csync_to_green == $past(hsync_dly))
        else $error("composite sync missing on green");
    a_composite_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
        composite && hmode == OMODE_PASS |=> !sync_out.line_sync)
        else $error("line sync driven in composite mode");
    a_hsync_shifted: assert property (@(posedge mclk) disable iff (!reset_n)
        hmode == OMODE_PASS && !composite && hpos_ff == 4'h2
        |=> sync_out.line_sync == $past(hpipe_ff[PIPE_DELAY+1]))
        else $error("shifted line sync delay wrong");
    a_pipe_entry: assert property (@(posedge mclk) disable iff (!reset_n)
        hpipe_ff[0] == ($past(lat_ff.line_sync) ^ $past(hinv)))
        else $error("line sync polarity wrong at pipe entry");
    a_row_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        !(interlace && cursor_en) |=> $stable(cursor_row_odd))
        else $error("cursor row moved while unused");

    c_border: cover property (@(posedge mclk) video_src == SRC_BORDER);
    c_pixel: cover property (@(posedge mclk) video_src == SRC_PIXEL);
    c_csync: cover property (@(posedge mclk) csync_to_green);
    c_hiz: cover property (@(posedge mclk) sync_out.frame_sync_oe_n);
    c_field: cover property (@(posedge mclk) cursor_row_odd);

endmodule // video_sync_blank_pipeline
`default_nettype wire

/* File: sync_source.sv */
// Display controller model: free-running load clock and video control pins
`default_nettype none
module sync_source
    import sync_blank_pkg::*;
(
    input wire logic mclk, // Pixel clock
    input wire logic reset_n, // Async reset, active low
    input wire logic field_mode, // Shared pin carries field parity
    input wire ctl_in_s want, // Pin levels the bench asks for
    output logic load_clock, // Load clock, a quarter of mclk
    output ctl_in_s ctl_in // Control pins towards the device
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase_ff;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            phase_ff <= 2'h0;
        else
            phase_ff <= phase_ff + 2'h1;
    end

    // Never stops, also outside display
    assign load_clock = phase_ff[1];

    // Pins move halfway through the low phase, one mclk before the rising load edge
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            ctl_in <= '0;
        else if (phase_ff == 2'h0)
        begin
            ctl_in.blank_n <= want.blank_n;
            ctl_in.line_sync <= want.line_sync;
            ctl_in.frame_sync <= want.frame_sync;
            // Parity only moves while blanked; border follows blank
            if (field_mode)
                ctl_in.shared <= want.blank_n ? ctl_in.shared : want.shared;
            else
                ctl_in.shared <= want.shared & want.blank_n;
        end
    end
endmodule // sync_source
`default_nettype wire

/* File: tb_top.sv */
// Self-checking testbench for the video sync and blank pipeline
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sync_blank_pkg::*;
    logic mclk, reset_n, load_clock, reg_wr, reg_rd, csync_to_green, cursor_row_odd;
    logic field_mode;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [2:0] video_src;
    ctl_in_s ctl_in, want;
    sync_out_s sync_out;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    int lag [2];

    sync_source i_source (.mclk(mclk), .reset_n(reset_n), .field_mode(field_mode), .want(want),
        .load_clock(load_clock), .ctl_in(ctl_in));
    video_sync_blank_pipeline i_dut (.mclk(mclk), .reset_n(reset_n),
        .load_clock(load_clock), .ctl_in(ctl_in), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sync_out(sync_out), .video_src(video_src), .csync_to_green(csync_to_green),
        .cursor_row_odd(cursor_row_odd));

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // ----------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------
    task automatic print_verdict;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(what, reg_rdata, exp);
    endtask

    // Long enough for latch, longest tap and output stage
    task automatic pins(input logic [3:0] v);
        @(posedge mclk);
        want <= ctl_in_s'(v);
        repeat (40) @(posedge mclk);
        #1;
    endtask

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        want = '0;
        field_mode = 1'b0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        #1;
        check("sync_out", sync_out, 16'h0000);
        check("video_src", video_src, SRC_BLANK);
        rd_chk("ctrl", OFS_SYNC_CTRL, RST_SYNC_CTRL);
        rd_chk("hpos", OFS_HPOS, RST_HPOS);
        rd_chk("unmapped", 4'hf, 16'h0000);
        for (int i = 0; i < 3; i++)
        begin
            pins({1'(i > 0), 1'(i > 1), 2'b00});
            check("video_src", video_src, 16'h1 << i);
        end
        rd_chk("status", OFS_STATUS, 16'h000c);
        pins(4'hf);
        check("sync_out", sync_out, 16'h000a);
        for (int m = 0; m < 4; m++)
        begin
            wr(OFS_SYNC_CTRL, 16'((m << POS_HMODE) | (m << POS_VMODE) | 12));
            pins(4'hf);
            check("line_oe_n", sync_out.line_sync_oe_n, 16'(m == 3));
            check("frame_oe_n", sync_out.frame_sync_oe_n, 16'(m == 3));
            if (m < 3)
            begin
                check("line_sync", sync_out.line_sync, 16'(m == 1));
                check("frame_sync", sync_out.frame_sync, 16'(m == 1));
            end
        end
        for (int v = 0; v < 2; v++)
        begin
            wr(OFS_SYNC_CTRL, 16'h0101 | 16'(v << POS_HINV));
            pins(4'hf);
            check("csync", csync_to_green, 16'(v == 0));
            check("line_sync", sync_out.line_sync, 16'h0000);
        end
        // Interlace: shared pin no longer means border
        wr(OFS_SYNC_CTRL, 16'h0202);
        field_mode <= 1'b1;
        for (int s = 1; s >= 0; s--)
        begin
            pins({1'b0, 1'(s), 2'b00});
            pins({1'b1, 1'(s), 2'b00});
            check("video_src", video_src, SRC_PIXEL);
            check("cursor_row", cursor_row_odd, 16'(s));
        end
        // Mid-run reset must restore the defaults
        field_mode <= 1'b0;
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        rd_chk("ctrl_rst", OFS_SYNC_CTRL, RST_SYNC_CTRL);
        check("row_rst", cursor_row_odd, 16'h0000);
        wr(OFS_SYNC_CTRL, 16'h0000);
        // Line lag measured against frame sync, which has no delay line
        for (int h = 0; h < 2; h++)
        begin
            wr(OFS_HPOS, 16'(2 * h));
            pins(4'h8);
            want <= ctl_in_s'(4'hb);
            n = 0;
            while (sync_out.frame_sync !== 1'b1 && n < 40)
            begin
                @(posedge mclk);
                #1;
                n++;
            end
            n = 0;
            while (sync_out.line_sync !== 1'b1 && n < 60)
            begin
                @(posedge mclk);
                #1;
                n++;
            end
            lag[h] = n;
        end
        check("line_lag", 16'(lag[0]), 16'(PIPE_NOMINAL));
        check("hpos_shift", 16'(lag[1] - lag[0]), 16'h0002);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
